// >>> rtl/sfm_consts.svh
// Constants for the servo fault monitor
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH
`define SFM_MAIN_LINK_DISC 8'h21
`define SFM_SUB_LINK_DISC 8'h00
`define SFM_MAIN_LINK_ERR 8'h21
`define SFM_SUB_LINK_ERR 8'h01
`define SFM_MAIN_DATA_ERR 8'h23
`define SFM_SUB_DATA_ERR 8'h00
`define SFM_MAIN_POS_ERR 8'h24
`define SFM_SUB_POS_ERR 8'h00
`define SFM_MAIN_SPD_ERR 8'h24
`define SFM_SUB_SPD_ERR 8'h01
`define SFM_STALL_NS 100000
`define SFM_CLK_MHZ 200
`define SFM_STALL_CYC ((`SFM_STALL_NS * `SFM_CLK_MHZ) / 1000)
`define SFM_DEPTH 8
`endif

// >>> rtl/sfm_log_mem.sv
// Small history memory of latched fault codes
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_log_mem (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire sfm_pkg::sfm_code_t wr_data,
	// Read port
	input wire logic [2:0] rd_addr,
	output sfm_pkg::sfm_code_t rd_data
);
	import sfm_pkg::*;
	sfm_code_t mem [`SFM_DEPTH];
	sfm_code_t rd_data_r;
	assign rd_data = rd_data_r;
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= mem[rd_addr];
		end
	end
endmodule

// >>> rtl/sfm_monitor.sv
// Servo fault monitor: encoder link and deviation checks
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_monitor #(
	parameter int STALL_CYC = `SFM_STALL_CYC
) (
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic enc_clk,
	input wire logic rst_n,
	// Encoder link side
	input wire sfm_pkg::sfm_frame_t enc_frame,
	// Configuration
	input wire logic [7:0] stall_limit,
	input wire logic [31:0] follow_window,
	input wire logic [31:0] speed_dev_limit,
	// Motion path
	input wire logic signed [31:0] pos_error,
	input wire logic signed [31:0] vel_demand,
	input wire logic signed [31:0] vel_actual,
	input wire logic halt_stop,
	input wire logic drive_prohibit,
	// Fault clear and readback
	input wire logic fault_clear,
	input wire logic [2:0] log_rd_addr,
	output logic fault_active,
	output sfm_pkg::sfm_code_t fault_code,
	output logic signed [31:0] vel_demand_filt,
	output sfm_pkg::sfm_code_t log_rd_data
);
	import sfm_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [32:0] abs33(input logic signed [32:0] v);
		abs33 = v[32] ? 33'(-v) : 33'(v);
	endfunction
	function automatic logic over_lim(input logic [32:0] mag, input logic [31:0] lim);
		over_lim = mag > {1'b0, lim};
	endfunction

	// ----------------------------------------
	// Link domain: frame event capture
	// ----------------------------------------
	logic enc_rst_m_r, enc_rst_r;
	logic enc_rst_m_nxt, enc_rst_nxt;
	logic ev_tog_r, ev_tog_nxt;
	logic le_tog_r, le_tog_nxt;
	logic de_tog_r, de_tog_nxt;
	always_ff @(posedge enc_clk or negedge rst_n) begin
		if (!rst_n) begin
			enc_rst_m_r <= 1'b0;
			enc_rst_r <= 1'b0;
		end else begin
			enc_rst_m_r <= enc_rst_m_nxt;
			enc_rst_r <= enc_rst_nxt;
		end
	end
	always_comb begin
		enc_rst_m_nxt = 1'b1;
		enc_rst_nxt = enc_rst_m_r;
	end
	always_comb begin
		ev_tog_nxt = ev_tog_r;
		le_tog_nxt = le_tog_r;
		de_tog_nxt = de_tog_r;
		if (enc_rst_r && enc_frame.valid) begin
			ev_tog_nxt = ~ev_tog_r;
			if (enc_frame.link_err) begin
				le_tog_nxt = ~le_tog_r;
			end else if (enc_frame.data_err) begin
				de_tog_nxt = ~de_tog_r;
			end
		end
	end
	always_ff @(posedge enc_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_tog_r <= 1'b0;
			le_tog_r <= 1'b0;
			de_tog_r <= 1'b0;
		end else begin
			ev_tog_r <= ev_tog_nxt;
			le_tog_r <= le_tog_nxt;
			de_tog_r <= de_tog_nxt;
		end
	end

	// ----------------------------------------
	// Crossing into the reference domain
	// ----------------------------------------
	logic [2:0] tog_m_r, tog_s_r, tog_d_r;
	logic [2:0] tog_m_nxt, tog_s_nxt, tog_d_nxt;
	always_comb begin
		tog_m_nxt = {de_tog_r, le_tog_r, ev_tog_r};
		tog_s_nxt = tog_m_r;
		tog_d_nxt = tog_s_r;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_m_r <= 3'h0;
			tog_s_r <= 3'h0;
			tog_d_r <= 3'h0;
		end else begin
			tog_m_r <= tog_m_nxt;
			tog_s_r <= tog_s_nxt;
			tog_d_r <= tog_d_nxt;
		end
	end
	// Each synced toggle edge is one event pulse
	logic frame_seen, link_err_ev, data_err_ev;
	assign frame_seen = tog_s_r[0] ^ tog_d_r[0];
	assign link_err_ev = tog_s_r[1] ^ tog_d_r[1];
	assign data_err_ev = tog_s_r[2] ^ tog_d_r[2];

	// ----------------------------------------
	// Clear synchroniser
	// ----------------------------------------
	// Clear may come from any clock
	logic clr_m_r, clr_s_r;
	logic clr_m_nxt, clr_s_nxt;
	always_comb begin
		clr_m_nxt = fault_clear;
		clr_s_nxt = clr_m_r;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_m_r <= 1'b0;
			clr_s_r <= 1'b0;
		end else begin
			clr_m_r <= clr_m_nxt;
			clr_s_r <= clr_s_nxt;
		end
	end

	// ----------------------------------------
	// Stall detection
	// ----------------------------------------
	logic [31:0] gap_cnt_r, gap_cnt_nxt;
	logic [7:0] stall_cnt_r, stall_cnt_nxt;
	logic disc_ev;
	always_comb begin
		gap_cnt_nxt = gap_cnt_r;
		stall_cnt_nxt = stall_cnt_r;
		disc_ev = 1'b0;
		if (frame_seen) begin
			gap_cnt_nxt = 32'h0;
		end else if (gap_cnt_r >= 32'(STALL_CYC - 1)) begin
			// One stall per STALL_CYC silent cycles; the gap count restarts
			gap_cnt_nxt = 32'h0;
			if (stall_cnt_r != 8'hff) begin
				stall_cnt_nxt = stall_cnt_r + 8'h01;
			end
		end else begin
			gap_cnt_nxt = gap_cnt_r + 32'h1;
		end
		if (stall_cnt_r > stall_limit) begin
			disc_ev = 1'b1;
		end
		if (clr_s_r) begin
			stall_cnt_nxt = 8'h0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt_r <= 32'h0;
			stall_cnt_r <= 8'h0;
		end else begin
			gap_cnt_r <= gap_cnt_nxt;
			stall_cnt_r <= stall_cnt_nxt;
		end
	end

	// ----------------------------------------
	// Deviation checks
	// ----------------------------------------
	logic signed [31:0] vdf_nxt, vdf_r;
	logic pos_ev, spd_ev;
	logic signed [32:0] spd_diff;
	always_comb begin
		vdf_nxt = vel_demand;
		if (halt_stop || drive_prohibit) begin
			vdf_nxt = 32'sh0;
		end
		// Wide difference so opposite signs cannot wrap
		spd_diff = 33'(vdf_r) - 33'(vel_actual);
		pos_ev = over_lim(abs33(33'(pos_error)), follow_window);
		spd_ev = (speed_dev_limit != 32'h0) &&
			over_lim(abs33(spd_diff), speed_dev_limit);
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vdf_r <= 32'sh0;
		end else begin
			vdf_r <= vdf_nxt;
		end
	end

	// ----------------------------------------
	// Fault latch
	// ----------------------------------------
	sfm_state_t st_r, st_nxt;
	sfm_code_t code_r, code_nxt;
	logic act_r, act_nxt;
	logic [2:0] wp_r, wp_nxt;
	logic log_we;
	sfm_code_t new_code;
	logic any_ev;
	always_comb begin
		any_ev = 1'b1;
		new_code = '0;
		if (disc_ev) begin
			new_code = '{`SFM_MAIN_LINK_DISC, `SFM_SUB_LINK_DISC};
		end else if (link_err_ev) begin
			new_code = '{`SFM_MAIN_LINK_ERR, `SFM_SUB_LINK_ERR};
		end else if (data_err_ev) begin
			new_code = '{`SFM_MAIN_DATA_ERR, `SFM_SUB_DATA_ERR};
		end else if (pos_ev) begin
			new_code = '{`SFM_MAIN_POS_ERR, `SFM_SUB_POS_ERR};
		end else if (spd_ev) begin
			new_code = '{`SFM_MAIN_SPD_ERR, `SFM_SUB_SPD_ERR};
		end else begin
			any_ev = 1'b0;
		end
	end

	// ----------------------------------------
	// Latch state machine
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		code_nxt = code_r;
		act_nxt = act_r;
		wp_nxt = wp_r;
		log_we = 1'b0;
		case (st_r)
			SFM_IDLE: begin
				if (any_ev) begin
					st_nxt = SFM_FAULT;
					code_nxt = new_code;
					act_nxt = 1'b1;
					log_we = 1'b1;
					wp_nxt = wp_r + 3'h1;
				end
			end
			SFM_FAULT: begin
				// Held until cleared; a live cause keeps it set
				if (clr_s_r && !any_ev) begin
					st_nxt = SFM_CLEAR;
				end
			end
			SFM_CLEAR: begin
				st_nxt = SFM_IDLE;
				act_nxt = 1'b0;
				code_nxt = '0;
			end
			default: begin
				st_nxt = SFM_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SFM_IDLE;
			code_r <= '0;
			act_r <= 1'b0;
			wp_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			code_r <= code_nxt;
			act_r <= act_nxt;
			wp_r <= wp_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign fault_active = act_r;
	assign fault_code = code_r;
	assign vel_demand_filt = vdf_r;

	// ----------------------------------------
	// History memory
	// ----------------------------------------
	sfm_log_mem u_log (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(log_we),
		.wr_addr(wp_r),
		.wr_data(new_code),
		.rd_addr(log_rd_addr),
		.rd_data(log_rd_data)
	);
endmodule

// >>> rtl/sfm_pkg.sv
// Types for the servo fault monitor
package sfm_pkg;
	typedef struct packed {
		logic [7:0] main_code;
		logic [7:0] sub_code;
	} sfm_code_t;
	typedef struct packed {
		logic valid;
		logic link_err;
		logic data_err;
	} sfm_frame_t;
	typedef enum logic [2:0] {
		SFM_IDLE = 3'b001,
		SFM_FAULT = 3'b010,
		SFM_CLEAR = 3'b100
	} sfm_state_t;
endpackage

// >>> test/sfm_enc_model.sv
// Encoder link model sending one frame every fourth link clock
`timescale 1ns/1ps
module sfm_enc_model (
	// Link clock and reset
	input wire logic enc_clk,
	input wire logic rst_n,
	// Bench control
	input wire logic run,
	input wire logic [1:0] err,
	// Frame out
	output sfm_pkg::sfm_frame_t frame
);
	logic [1:0] cnt_r;
	always_ff @(posedge enc_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			frame <= '0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			frame.valid <= run && cnt_r == 2'h3;
			if (run && cnt_r == 2'h3) begin
				frame.link_err <= err[1];
				frame.data_err <= err[0];
			end else begin
				// Idle lines toggle, never keep the last value
				frame.link_err <= ~frame.link_err;
				frame.data_err <= ~frame.data_err;
			end
		end
	end
endmodule

// >>> test/sfm_monitor_properties.sv
// Checker for the servo fault monitor
`timescale 1ns/1ps
module sfm_chk (
	// Watched ports
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [31:0] follow_window,
	input wire logic [31:0] speed_dev_limit,
	input wire logic signed [31:0] pos_error,
	input wire logic signed [31:0] vel_demand,
	input wire logic signed [31:0] vel_actual,
	input wire logic halt_stop,
	input wire logic drive_prohibit,
	input wire logic fault_clear,
	input wire logic fault_active,
	input wire sfm_pkg::sfm_code_t fault_code,
	input wire logic signed [31:0] vel_demand_filt
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	pos_fault_a: assert property (!fault_active && pos_error > 0 &&
		$unsigned(pos_error) > follow_window |=> fault_active) else $error("pos fault missed");
	spd_fault_a: assert property (!fault_active && speed_dev_limit != 0 &&
		vel_demand_filt > vel_actual && $unsigned(vel_demand_filt - vel_actual) >
		speed_dev_limit |-> ##[1:2] fault_active) else $error("speed fault missed");
	spd_off_a: assert property ($rose(fault_active) && fault_code == 16'h2401 |->
		$past(speed_dev_limit) != 0) else $error("speed check not disabled");
	stop_zero_a: assert property (halt_stop || drive_prohibit |=>
		vel_demand_filt == 0) else $error("demand not forced to zero");
	demand_pass_a: assert property (!halt_stop && !drive_prohibit |=>
		vel_demand_filt == $past(vel_demand)) else $error("demand not passed");
	code_hold_a: assert property (!fault_clear[*4] ##0 fault_active |=>
		fault_active && $stable(fault_code)) else $error("fault code not held");
	idle_code_a: assert property (!fault_active |-> fault_code == '0)
		else $error("code without fault");
	code_set_a: assert property ($rose(fault_active) |-> fault_code inside
		{16'h2100, 16'h2101, 16'h2300, 16'h2400, 16'h2401}) else $error("bad code");
endmodule
bind sfm_monitor sfm_chk u_chk (.ref_clk, .rst_n, .follow_window, .speed_dev_limit,
	.pos_error, .vel_demand, .vel_actual, .halt_stop, .drive_prohibit, .fault_clear,
	.fault_active, .fault_code, .vel_demand_filt);

// >>> test/tb_top.sv
// Testbench for the servo fault monitor
`timescale 1ns/1ps
module tb_top;
	import sfm_pkg::*;
	logic ref_clk = 0, enc_clk = 0, rst_n = 0, run = 1, halt_stop = 0, drive_prohibit = 0;
	logic fault_clear = 0, fault_active;
	logic [1:0] err = '0;
	logic [2:0] log_rd_addr = '0;
	logic [7:0] stall_limit = 8'h02;
	logic [31:0] follow_window = 32'h64, speed_dev_limit = '0;
	logic signed [31:0] pos_error = '0, vel_demand = '0, vel_actual = '0, vel_demand_filt;
	sfm_frame_t enc_frame;
	sfm_code_t fault_code, log_rd_data;
	int fails = 0, n_compared = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	initial #1.3 forever #7.5 enc_clk = ~enc_clk;
	sfm_enc_model enc (.enc_clk, .rst_n, .run, .err, .frame(enc_frame));
	sfm_monitor #(.STALL_CYC(50)) dut (.ref_clk, .enc_clk, .rst_n, .enc_frame, .stall_limit,
		.follow_window, .speed_dev_limit, .pos_error, .vel_demand, .vel_actual, .halt_stop,
		.drive_prohibit, .fault_clear, .log_rd_addr, .fault_active, .fault_code,
		.vel_demand_filt, .log_rd_data);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wait_fault(input logic [15:0] exp);
		for (int i = 0; i < 400 && fault_active !== 1'b1; i++)
			cyc(1);
		chk(fault_code, exp);
	endtask
	task automatic clear;
		fault_clear = 1'h1;
		cyc(8);
		fault_clear = 1'h0;
		cyc(2);
		chk(fault_active, 0);
	endtask
	task automatic t_pos;
		pos_error = 32'h64;
		cyc(6);
		chk(fault_active, 0);
		pos_error = 32'h65;
		wait_fault(16'h2400);
		pos_error = '0;
		cyc(6);
		chk(fault_code, 16'h2400);
		chk(log_rd_data, 16'h2400);
		clear();
	endtask
	task automatic t_spd;
		vel_demand = 32'h1f4;
		cyc(8);
		chk(fault_active, 0);
		speed_dev_limit = 32'h1f4;
		cyc(6);
		chk(fault_active, 0);
		vel_demand = 32'h1f5;
		wait_fault(16'h2401);
		vel_demand = '0;
		clear();
		speed_dev_limit = '0;
	endtask
	task automatic t_stop;
		vel_demand = 32'h100;
		vel_actual = 32'h100;
		drive_prohibit = 1'h1;
		cyc(2);
		chk(vel_demand_filt, 0);
		drive_prohibit = 1'h0;
		cyc(2);
		chk(vel_demand_filt, 32'h100);
		speed_dev_limit = 32'h80;
		cyc(4);
		chk(fault_active, 0);
		halt_stop = 1'h1;
		wait_fault(16'h2401);
		halt_stop = 1'h0;
		speed_dev_limit = '0;
		clear();
	endtask
	task automatic t_link;
		logic [1:0] e[3] = '{2'h2, 2'h1, 2'h3};
		logic [15:0] x[3] = '{16'h2101, 16'h2300, 16'h2101};
		for (int k = 0; k < 3; k++) begin
			err = e[k];
			wait_fault(x[k]);
			err = '0;
			cyc(30);
			clear();
		end
	endtask
	task automatic t_stall;
		run = 1'h0;
		cyc(120);
		chk(fault_active, 0);
		wait_fault(16'h2100);
		run = 1'h1;
		cyc(10);
		clear();
		stall_limit = 8'h00;
		run = 1'h0;
		cyc(30);
		chk(fault_active, 0);
		wait_fault(16'h2100);
		run = 1'h1;
		cyc(10);
		clear();
		stall_limit = 8'h02;
	endtask
	task automatic t_log;
		logic [15:0] x[8] = '{16'h2400, 16'h2401, 16'h2401, 16'h2101, 16'h2300, 16'h2101,
			16'h2100, 16'h2100};
		for (int k = 0; k < 8; k++) begin
			log_rd_addr = 3'(k);
			cyc(2);
			chk(log_rd_data, x[k]);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(12);
		rst_n = 1'h1;
		cyc(4);
		t_pos();
		t_spd();
		t_stop();
		t_link();
		t_stall();
		t_log();
		test_done();
	end
	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule
